/* File: inc/ppe_pkg.sv */
/*
 * Shared constants, types and helpers of the PCI parity, error and reset unit.
 * Assumes one clock, mclk, which is the bus clock, and a synchronous active-low reset.
 */
// Functional notes
// - Parity is even over the thirty-two address/data lines and the four command/byte-enable lines.
// - Parity covers every one of those lines in every phase, whether or not a line carries a meaningful value.
// - Every bus signal is sampled on the rising clock edge, and the logic has no dependence on the clock rate.
// - A data parity error seen while bus master sets system-error bit 13 and data-parity-report bit 24.
// - After a master data parity error the burst is finished, then the unit halts until bit 13 is cleared.
// - The parity-error pin is driven active on a parity error in received data, master reads or slave writes.
// - While reset is held every bus output is released and every open-drain signal floats.
// - An address parity error drives the system-error pin and sets bit 30, but only while enable bit 8 is set.
// - The system-error pin asserts exactly two clocks after the clock that carried the faulty address.
// - The bus request is asserted when master ownership of the bus is needed, except while an error is pending or the unit is halted.
package ppe_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          PPE_APB_AW      = 8;
    localparam logic [7:0]  PPE_OFS_STATUS  = 8'h00;
    localparam logic [7:0]  PPE_OFS_CONFIG_COMMAND_STATUS    = 8'h04;
    localparam logic [7:0]  PPE_OFS_MASK    = 8'h08;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          PPE_ST_HALTED   = 0;
    localparam int          PPE_ST_ADDR_PE  = 1;
    localparam int          PPE_ST_DATA_PE  = 2;
    localparam int          PPE_ST_SYS_ERR  = 13;
    localparam int          PPE_CF_SERR_EN  = 8;
    localparam int          PPE_CF_DPR      = 24;
    localparam int          PPE_CF_SSE      = 30;

    localparam logic [31:0] PPE_ST_EVT_MASK = 32'h0000_2006;
    localparam logic [31:0] PPE_CF_RW_MASK  = 32'h0000_0100;
    localparam logic [31:0] PPE_CF_W1C_MASK = 32'h4100_0000;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] PPE_STATUS_RST  = 32'h0000_0000;
    localparam logic [31:0] PPE_CONFIG_COMMAND_STATUS_RST    = 32'h0000_0000;
    localparam logic [31:0] PPE_MASK_RST    = 32'h0000_0000;
    localparam int          PPE_RST_MIN_CYC = 10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PPE_RUN  = 3'b001,
        PPE_PEND = 3'b010,
        PPE_HALT = 3'b100
    } ppe_run_t;

    // Write-one-to-clear with set winning over clear
    function automatic logic [31:0] ppe_w1c(input logic [31:0] cur,
                                            input logic [31:0] set,
                                            input logic [31:0] clr);
        ppe_w1c = (cur & ~clr) | set;
    endfunction

endpackage

/* File: inc/ppe_par_if.sv */
/*
 * Carrier between the top and the parity unit: bus lines in, parity of the previous clock out.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
interface ppe_par_if;
    logic [31:0] bus_ad;
    logic [3:0]  bus_cbe;
    logic        par_prev;

    modport calc (input bus_ad, input bus_cbe, output par_prev);
    modport user (output bus_ad, output bus_cbe, input par_prev);
endinterface

/* File: logic/ppe_parity.sv */
/*
 * Registered even-parity generator over the address/data and command lines.
 * Assumes the user presents the lines actually on the bus each clock.
 */
`timescale 1ns/1ps
module ppe_parity
    import ppe_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    ppe_par_if.calc   pif
);
    logic par_nxt;
    logic par_r;

    // Even parity over all 36 lines, meaningful or not
    assign par_nxt = ^{pif.bus_ad, pif.bus_cbe};

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            par_r <= 1'b0;
        end else begin
            par_r <= par_nxt;
        end
    end

    assign pif.par_prev = par_r;
endmodule

/* File: logic/ppe_top.sv */
/*
 * PCI parity generation and checking, error signalling, bus request and halt control,
 * with an APB register slave and a level interrupt.
 * Assumes bus pins are synchronous to mclk and the core states its bus role every clock.
 */
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module ppe_top
    import ppe_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PPE_APB_AW-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Bus pins
    input  wire logic [31:0]           ad_i,
    output logic [31:0]                ad_o,
    output logic                       ad_oe,
    input  wire logic [3:0]            cbe_b_i,
    output logic [3:0]                 cbe_b_o,
    output logic                       cbe_oe,
    input  wire logic                  par_i,
    output logic                       par_o,
    output logic                       par_oe,
    input  wire logic                  frame_b_i,
    input  wire logic                  irdy_b_i,
    input  wire logic                  trdy_b_i,
    input  wire logic                  perr_b_i,
    output logic                       perr_b_o,
    output logic                       perr_oe,
    output logic                       serr_b_o,
    output logic                       serr_oe,
    output logic                       req_b_o,
    output logic                       req_oe,
    // Core side
    input  wire logic                  core_req,
    input  wire logic                  core_drive,
    input  wire logic [31:0]           core_ad,
    input  wire logic [3:0]            core_cbe_b,
    input  wire logic                  core_mst,
    input  wire logic                  core_rd,
    input  wire logic                  core_tgt_wr,
    output logic                       core_halt,
    output logic                       irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ppe_par_if pif ();

    ppe_run_t    run_r;
    ppe_run_t    run_nxt;

    logic [31:0] ad_o_r;
    logic [3:0]  cbe_o_r;
    logic        ad_oe_r;
    logic        par_o_r;
    logic        par_oe_r;
    logic        frame_d_r;
    logic        addr_ph_r;
    logic        rx_ph_r;
    logic        rx_mst_r;
    logic        perr_oe_r;
    logic        perr_o_r;
    logic        serr_oe_r;
    logic        req_o_r;
    logic        req_oe_r;
    logic        halt_r;
    logic        irq_r;

    logic [31:0] status_register_r;
    logic [31:0] status_register_nxt;
    logic [31:0] config_command_status_r;
    logic [31:0] config_command_status_nxt;
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    // ------------------------------------------------------------
    // Bus view and phase decode
    // ------------------------------------------------------------
    logic        addr_ph_now;
    logic        rx_ph_now;
    logic        par_bad;
    logic        addr_pe;
    logic        data_pe;
    logic        mst_data_pe;
    logic        serr_fire;
    logic        bus_idle;

    // Lines actually on the bus this clock
    assign pif.bus_ad   = ad_oe_r ? ad_o_r : ad_i;
    assign pif.bus_cbe  = ad_oe_r ? cbe_o_r : cbe_b_i;

    // Address phase from another agent: frame newly low
    assign addr_ph_now  = !frame_b_i && frame_d_r && !ad_oe_r;
    // Completed data phase in which this unit receives
    assign rx_ph_now    = !irdy_b_i && !trdy_b_i && ((core_mst && core_rd) || core_tgt_wr) && !ad_oe_r;

    // Parity of the previous clock's lines against the parity pin now
    assign par_bad      = par_i != pif.par_prev;
    assign addr_pe      = addr_ph_r && par_bad;
    assign data_pe      = rx_ph_r && par_bad;
    assign mst_data_pe  = data_pe && rx_mst_r;
    assign serr_fire    = addr_pe && config_command_status_r[PPE_CF_SERR_EN];
    assign bus_idle     = frame_b_i && irdy_b_i;

    ppe_parity u_parity (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pif   (pif.calc)
    );

    // ------------------------------------------------------------
    // Bus sampling and phase pipeline
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            frame_d_r <= 1'b1;
            addr_ph_r <= 1'b0;
            rx_ph_r   <= 1'b0;
            rx_mst_r  <= 1'b0;
        end else begin
            frame_d_r <= frame_b_i;
            addr_ph_r <= addr_ph_now;
            rx_ph_r   <= rx_ph_now;
            rx_mst_r  <= core_mst && core_rd;
        end
    end

    // ------------------------------------------------------------
    // Address/data drive and parity one clock later
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ad_o_r   <= 32'h0000_0000;
            cbe_o_r  <= 4'hF;
            ad_oe_r  <= 1'b0;
            par_o_r  <= 1'b0;
            par_oe_r <= 1'b0;
        end else begin
            ad_o_r   <= core_ad;
            cbe_o_r  <= core_cbe_b;
            ad_oe_r  <= core_drive && (run_nxt != PPE_HALT);
            par_o_r  <= ^{ad_o_r, cbe_o_r};
            par_oe_r <= ad_oe_r;
        end
    end

    // ------------------------------------------------------------
    // Error pins
    // ------------------------------------------------------------
    // Parity-error pin: low for the error clock, then driven high once before release
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            perr_oe_r <= 1'b0;
            perr_o_r  <= 1'b1;
        end else begin
            perr_oe_r <= data_pe || !perr_o_r;
            perr_o_r  <= !data_pe;
        end
    end

    // System-error pin: open drain, pulled low for one clock
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            serr_oe_r <= 1'b0;
        end else begin
            serr_oe_r <= serr_fire;
        end
    end

    // ------------------------------------------------------------
    // Halt control
    // ------------------------------------------------------------
    always_comb begin
        run_nxt = run_r;
        case (run_r)
            PPE_RUN: begin
                if (mst_data_pe) begin
                    run_nxt = PPE_PEND;
                end
            end
            PPE_PEND: begin
                if (bus_idle) begin
                    run_nxt = PPE_HALT;
                end
            end
            PPE_HALT: begin
                if (!status_register_r[PPE_ST_SYS_ERR]) begin
                    run_nxt = PPE_RUN;
                end
            end
            default: begin
                run_nxt = PPE_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            run_r  <= PPE_RUN;
            halt_r <= 1'b0;
        end else begin
            run_r  <= run_nxt;
            halt_r <= run_nxt == PPE_HALT;
        end
    end

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    // No new ownership once an error is pending or halted
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            req_o_r  <= 1'b1;
            req_oe_r <= 1'b0;
        end else begin
            req_o_r  <= !(core_req && run_nxt == PPE_RUN);
            req_oe_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        apb_acc;
    logic        apb_done;
    logic        apb_wr;
    logic        hit_status;
    logic        hit_config_command_status;
    logic        hit_mask;
    logic        hit_any;
    logic [31:0] st_set;
    logic [31:0] st_clr;
    logic [31:0] cf_set;
    logic [31:0] cf_clr;
    logic [31:0] rd_mux;

    assign apb_acc    = psel && penable;
    assign apb_done   = apb_acc && pready_r;
    assign apb_wr     = apb_done && pwrite && !pslverr_r;
    assign hit_status = paddr == PPE_OFS_STATUS;
    assign hit_config_command_status   = paddr == PPE_OFS_CONFIG_COMMAND_STATUS;
    assign hit_mask   = paddr == PPE_OFS_MASK;
    assign hit_any    = hit_status || hit_config_command_status || hit_mask;

    assign st_set     = {18'h0_0000, mst_data_pe, 10'h000, data_pe, addr_pe, 1'b0};
    assign st_clr     = (apb_wr && hit_status) ? (pwdata & PPE_ST_EVT_MASK) : 32'h0000_0000;
    assign cf_set     = {1'b0, serr_fire, 5'h00, mst_data_pe, 24'h00_0000};
    assign cf_clr     = (apb_wr && hit_config_command_status) ? (pwdata & PPE_CF_W1C_MASK) : 32'h0000_0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_comb begin
        status_register_nxt = ppe_w1c(status_register_r & PPE_ST_EVT_MASK, st_set, st_clr);
        status_register_nxt[PPE_ST_HALTED] = halt_r;
    end

    always_comb begin
        config_command_status_nxt = ppe_w1c(config_command_status_r & PPE_CF_W1C_MASK, cf_set, cf_clr);
        if (apb_wr && hit_config_command_status) begin
            config_command_status_nxt[PPE_CF_SERR_EN] = pwdata[PPE_CF_SERR_EN];
        end else begin
            config_command_status_nxt[PPE_CF_SERR_EN] = config_command_status_r[PPE_CF_SERR_EN];
        end
    end

    assign mask_nxt = (apb_wr && hit_mask) ? (pwdata & PPE_ST_EVT_MASK) : mask_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            status_register_r       <= PPE_STATUS_RST;
            config_command_status_r <= PPE_CONFIG_COMMAND_STATUS_RST;
            mask_r                  <= PPE_MASK_RST;
        end else begin
            status_register_r       <= status_register_nxt;
            config_command_status_r <= config_command_status_nxt;
            mask_r                  <= mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait state, data and error registered
    // ------------------------------------------------------------
    assign rd_mux = hit_status ? status_register_r :
                    hit_config_command_status   ? config_command_status_r :
                    hit_mask   ? mask_r : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_acc && !pready_r;
            pslverr_r <= apb_acc && !pready_r && !hit_any;
            prdata_r  <= (apb_acc && !pready_r && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_register_nxt & mask_nxt & PPE_ST_EVT_MASK);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign ad_o      = ad_o_r;
    assign ad_oe     = ad_oe_r;
    assign cbe_b_o   = cbe_o_r;
    assign cbe_oe    = ad_oe_r;
    assign par_o     = par_o_r;
    assign par_oe    = par_oe_r;
    assign perr_b_o  = perr_o_r;
    assign perr_oe   = perr_oe_r;
    assign serr_b_o  = 1'b0;
    assign serr_oe   = serr_oe_r;
    assign req_b_o   = req_o_r;
    assign req_oe    = req_oe_r;
    assign core_halt = halt_r;
    assign irq       = irq_r;

endmodule

/* File: tb/ppe_monitor.sv */
/* Checker of the parity, error and reset unit, bound to ppe_top.
   Assumes the top module's ports only and one clock domain. */
`timescale 1ns/1ps
module ppe_monitor
    import ppe_pkg::*;
(
    input logic        mclk,
    input logic        rst_b,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic [31:0] ad_i,
    input logic [31:0] ad_o,
    input logic        ad_oe,
    input logic [3:0]  cbe_b_i,
    input logic [3:0]  cbe_b_o,
    input logic        par_i,
    input logic        par_o,
    input logic        par_oe,
    input logic        frame_b_i,
    input logic        irdy_b_i,
    input logic        trdy_b_i,
    input logic        perr_b_o,
    input logic        perr_oe,
    input logic        serr_b_o,
    input logic        serr_oe,
    input logic        req_b_o,
    input logic        req_oe,
    input logic        core_req,
    input logic        core_drive,
    input logic [31:0] core_ad,
    input logic [3:0]  core_cbe_b,
    input logic        core_mst,
    input logic        core_rd,
    input logic        core_tgt_wr,
    input logic        core_halt
);
    // ----------
    // Helpers
    // ----------
    logic en_r;
    logic in_rst_r = 1'b0;
    wire  apb_wr   = psel && penable && pready && pwrite;

    // Shadow of the system-error enable bit
    always_ff @(posedge mclk) begin
        if (!rst_b)
            en_r <= 1'b0;
        else if (apb_wr && paddr == PPE_OFS_CONFIG_COMMAND_STATUS)
            en_r <= pwdata[PPE_CF_SERR_EN];
    end

    always @(posedge mclk)
        in_rst_r <= !rst_b;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_addr_bad;
        ($fell(frame_b_i) && !ad_oe) ##1 (en_r && par_i != ^{$past(ad_i), $past(cbe_b_i)});
    endsequence
    sequence s_data_bad;
        (!irdy_b_i && !trdy_b_i && !ad_oe && (core_mst && core_rd || core_tgt_wr))
        ##1 (par_i != ^{$past(ad_i), $past(cbe_b_i)});
    endsequence

    // ----------
    // Assertions
    // ----------
    a_par_even: assert property (
        ad_oe |=> par_oe && par_o == ^{$past(ad_o), $past(cbe_b_o)}) else $error("parity out wrong");
    a_drive_copy: assert property (
        core_drive ##1 !core_halt |-> ad_oe && ad_o == $past(core_ad) && cbe_b_o == $past(core_cbe_b))
        else $error("bus lines not driven from core");
    a_serr_timing: assert property (
        s_addr_bad |=> serr_oe && !serr_b_o ##1 !serr_oe) else $error("serr pulse misplaced");
    a_serr_gate: assert property (
        serr_oe |-> $past(en_r)) else $error("serr while disabled");
    a_perr_pulse: assert property (
        s_data_bad |=> perr_oe && !perr_b_o ##1 perr_oe && perr_b_o ##1 !perr_oe)
        else $error("perr pulse wrong");
    a_halt_quiet: assert property (
        core_halt |-> !ad_oe && req_b_o) else $error("bus used while halted");
    a_req_cause: assert property (
        !req_b_o |-> $past(core_req) && req_oe) else $error("request without cause");
    a_apb_wait: assert property (
        s_access |-> !pready ##1 pready ##1 !pready) else $error("apb answer misplaced");
    a_reset_float: assert property (disable iff (1'b0)
        in_rst_r && !rst_b |-> !ad_oe && !par_oe && !perr_oe && !serr_oe && !req_oe)
        else $error("pin driven in reset");
endmodule

bind ppe_top ppe_monitor i_ppe_monitor (
    .mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .ad_i, .ad_o, .ad_oe, .cbe_b_i, .cbe_b_o, .par_i, .par_o, .par_oe,
    .frame_b_i, .irdy_b_i, .trdy_b_i, .perr_b_o, .perr_oe, .serr_b_o, .serr_oe,
    .req_b_o, .req_oe, .core_req, .core_drive, .core_ad, .core_cbe_b,
    .core_mst, .core_rd, .core_tgt_wr, .core_halt
);

/* File: tb/ppe_bus_model.sv */
/* Bus agent model: one address phase and one data phase per transfer.
   Assumes mclk is the bus clock; the bench resolves shared lines. */
`timescale 1ns/1ps
module ppe_bus_model (
    input  logic        mclk,
    output logic [31:0] m_ad,
    output logic [3:0]  m_cbe_b,
    output logic        m_par,
    output logic        frame_b,
    output logic        irdy_b,
    output logic        trdy_b
);
    initial begin
        m_ad = 32'h0;
        m_cbe_b = 4'hF;
        m_par = 1'b0;
        frame_b = 1'b1;
        irdy_b = 1'b1;
        trdy_b = 1'b1;
    end

    // ----------
    // Transfer, with optional bad parity per phase
    // ----------
    task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c,
                        input logic bad_a, input logic bad_d);
        @(posedge mclk);
        frame_b <= 1'b0;
        m_ad <= a;
        m_cbe_b <= c;
        @(posedge mclk);
        frame_b <= 1'b1;
        irdy_b <= 1'b0;
        trdy_b <= 1'b0;
        m_ad <= d;
        m_cbe_b <= 4'h0;
        m_par <= ^{a, c} ^ bad_a;
        @(posedge mclk);
        irdy_b <= 1'b1;
        trdy_b <= 1'b1;
        m_ad <= ~d;
        m_cbe_b <= 4'hF;
        m_par <= ^{d, 4'h0} ^ bad_d;
        @(posedge mclk);
        m_par <= ~m_par;
    endtask
endmodule

/* File: tb/tb_pci_parity_error_reset.sv */
/* Self-checking bench of ppe_top with APB tasks and a bus agent model.
   Assumes ppe_pkg, the design, ppe_bus_model and ppe_monitor are compiled. */
`timescale 1ns/1ps
module tb_pci_parity_error_reset
    import ppe_pkg::*;
;
    logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        core_req = 1'b0, core_drive = 1'b0, core_mst = 1'b0, core_rd = 1'b0, core_tgt_wr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, core_ad = 32'h0, q, prdata, ad_o, m_ad;
    logic [3:0]  core_cbe_b = 4'hF, cbe_b_o, m_cbe_b;
    logic        err, pready, pslverr, ad_oe, cbe_oe, par_o, par_oe, perr_b_o, perr_oe;
    logic        serr_b_o, serr_oe, req_b_o, req_oe, core_halt, irq, m_par, frame_b, irdy_b, trdy_b;
    logic [31:0] pat [4] = '{32'h0, 32'hFFFF_FFFF, 32'h1, 32'h8000_0001};
    int          mismatches = 0, tests_run = 0, serr_cnt = 0, perr_cnt = 0;
    wire  [31:0] ad_w   = ad_oe ? ad_o : m_ad;
    wire  [3:0]  cbe_w  = cbe_oe ? cbe_b_o : m_cbe_b;
    wire         par_w  = par_oe ? par_o : m_par;
    wire         perr_w = perr_oe ? perr_b_o : 1'b1;

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        serr_cnt <= serr_cnt + int'(serr_oe === 1'b1);
        perr_cnt <= perr_cnt + int'(perr_oe === 1'b1 && perr_b_o === 1'b0);
    end

    ppe_top i_ppe_top (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ad_i(ad_w), .ad_o, .ad_oe, .cbe_b_i(cbe_w), .cbe_b_o, .cbe_oe, .par_i(par_w), .par_o, .par_oe,
        .frame_b_i(frame_b), .irdy_b_i(irdy_b), .trdy_b_i(trdy_b), .perr_b_i(perr_w), .perr_b_o, .perr_oe,
        .serr_b_o, .serr_oe, .req_b_o, .req_oe, .core_req, .core_drive, .core_ad, .core_cbe_b,
        .core_mst, .core_rd, .core_tgt_wr, .core_halt, .irq);
    ppe_bus_model i_ppe_bus_model (.mclk, .m_ad, .m_cbe_b, .m_par, .frame_b, .irdy_b, .trdy_b);

    // ----------
    // Tasks
    // ----------
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register read", e, q);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------
    // Tests
    // ----------
    initial begin
        repeat (PPE_RST_MIN_CYC) @(posedge mclk);
        chk("pins in reset", 32'h1, {ad_oe, cbe_oe, par_oe, perr_oe, serr_oe, req_oe, req_b_o});
        rst_b <= 1'b1;
        rd(PPE_OFS_STATUS, PPE_STATUS_RST);
        rd(PPE_OFS_CONFIG_COMMAND_STATUS, PPE_CONFIG_COMMAND_STATUS_RST);
        apb(1'b1, PPE_OFS_MASK, 32'hFFFF_FFFF);
        rd(PPE_OFS_MASK, PPE_ST_EVT_MASK);
        apb(1'b1, PPE_OFS_MASK, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 32'h1, err);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            core_drive <= 1'b1;
            core_ad <= pat[i];
            core_cbe_b <= i[3:0];
            @(posedge mclk);
            core_drive <= 1'b0;
            @(posedge mclk);
            chk("bus copy", pat[i], ad_o);
            @(posedge mclk);
            chk("parity out", {1'b1, ^{pat[i], i[3:0]}}, {par_oe, par_o});
        end
        $display("test parity out done");
        i_ppe_bus_model.xfer(32'h0000_1000, 32'h5A5A_0001, 4'h7, 1'b1, 1'b0);
        repeat (3) @(posedge mclk);
        chk("serr disabled", 32'h0, serr_cnt);
        rd(PPE_OFS_STATUS, 32'h2);
        apb(1'b1, PPE_OFS_STATUS, 32'h2);
        apb(1'b1, PPE_OFS_CONFIG_COMMAND_STATUS, 32'h100);
        i_ppe_bus_model.xfer(32'h0000_1004, 32'h0000_0003, 4'h7, 1'b0, 1'b0);
        i_ppe_bus_model.xfer(32'h0000_1008, 32'h0000_0007, 4'h7, 1'b1, 1'b0);
        repeat (3) @(posedge mclk);
        chk("serr pulses", 32'h1, serr_cnt);
        rd(PPE_OFS_CONFIG_COMMAND_STATUS, 32'h4000_0100);
        apb(1'b1, PPE_OFS_CONFIG_COMMAND_STATUS, 32'h4000_0100);
        rd(PPE_OFS_CONFIG_COMMAND_STATUS, 32'h100);
        apb(1'b1, PPE_OFS_STATUS, 32'h2);
        $display("test address parity done");
        core_tgt_wr <= 1'b1;
        i_ppe_bus_model.xfer(32'h0000_2000, 32'h0F0F_0F0F, 4'h7, 1'b0, 1'b1);
        repeat (4) @(posedge mclk);
        chk("perr pulses", 32'h1, perr_cnt);
        chk("no halt, masked", 32'h0, {core_halt, irq});
        rd(PPE_OFS_STATUS, 32'h4);
        apb(1'b1, PPE_OFS_STATUS, 32'h4);
        core_tgt_wr <= 1'b0;
        $display("test slave write error done");
        apb(1'b1, PPE_OFS_MASK, 32'h2006);
        core_mst <= 1'b1;
        core_rd <= 1'b1;
        core_req <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("request", 32'h0, req_b_o);
        i_ppe_bus_model.xfer(32'h0000_3000, 32'hC3C3_0001, 4'h6, 1'b0, 1'b1);
        repeat (2) @(posedge mclk);
        core_drive <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("halt state", 32'hE, {core_halt, irq, req_b_o, ad_oe});
        core_drive <= 1'b0;
        rd(PPE_OFS_STATUS, 32'h2005);
        rd(PPE_OFS_CONFIG_COMMAND_STATUS, 32'h0100_0100);
        apb(1'b1, PPE_OFS_STATUS, 32'h2004);
        repeat (3) @(posedge mclk);
        chk("resumed", 32'h0, {core_halt, irq, req_b_o});
        apb(1'b1, PPE_OFS_CONFIG_COMMAND_STATUS, 32'h0100_0100);
        rd(PPE_OFS_CONFIG_COMMAND_STATUS, 32'h100);
        $display("test master read error done");
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
endmodule
